// ==== umsi_pkg.sv ====
/*
  Package for the modem status / interrupt enable / scratch register bank.
  Assumes an APB master with 32-bit data; registers sit in the low byte.
*/
package umsi_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] UMSI_MSR_OFF  = 8'h00;
  localparam logic [7:0] UMSI_SCR_OFF  = 8'h04;
  localparam logic [7:0] UMSI_IEN_OFF  = 8'h08;
  localparam logic [7:0] UMSI_EFR_OFF  = 8'h0C;
  localparam logic [7:0] UMSI_IOC_OFF  = 8'h10;
  localparam logic [7:0] UMSI_MCR_OFF  = 8'h14;
  localparam logic [7:0] UMSI_SRC_OFF  = 8'h18;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int UMSI_MSR_CD     = 7;
  localparam int UMSI_MSR_RI     = 6;
  localparam int UMSI_MSR_DSR    = 5;
  localparam int UMSI_MSR_CTS    = 4;
  localparam int UMSI_MSR_DCD    = 3;
  localparam int UMSI_MSR_TERI   = 2;
  localparam int UMSI_MSR_DDSR   = 1;
  localparam int UMSI_MSR_DCTS   = 0;
  localparam int UMSI_IEN_CTS    = 7;
  localparam int UMSI_IEN_RTS    = 6;
  localparam int UMSI_IEN_XOFF   = 5;
  localparam int UMSI_IEN_SLEEP  = 4;
  localparam int UMSI_IEN_MODEM  = 3;
  localparam int UMSI_IEN_LINE   = 2;
  localparam int UMSI_IEN_TX     = 1;
  localparam int UMSI_IEN_RX     = 0;
  localparam int UMSI_EFR_ENH    = 4;
  localparam int UMSI_IOC_MODEM  = 1;
  localparam int UMSI_MCR_LOOP   = 4;
  localparam int UMSI_MCR_RTS    = 1;
  localparam int UMSI_MCR_DTR    = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] UMSI_REG_RST    = 8'h00;
  localparam logic [3:0] UMSI_INPUT_RST  = 4'hF;
  localparam logic [3:0] UMSI_IEN_UPPER  = 4'hF;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } umsi_modem_in_type;

  typedef struct packed {
    logic line_err;
    logic rx_data;
    logic tx_below;
    logic xoff_rcvd;
    logic cts_rise;
    logic rts_rise;
  } umsi_src_type;

endpackage : umsi_pkg

// ==== umsi_sync.sv ====
/*
  Three-stage synchroniser with agreement filter.
  Assumes an asynchronous input; output changes when stages two and three agree.
*/
`timescale 1ns/10ps
`default_nettype none
module umsi_sync
  import umsi_pkg::*;
#(
  parameter int       WIDTH = 4,
  parameter bit [3:0] RST   = UMSI_INPUT_RST
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= RST[WIDTH-1:0];
      s2_r <= RST[WIDTH-1:0];
      s3_r <= RST[WIDTH-1:0];
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Hold last agreed value; a single-cycle glitch never reaches the flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_out <= RST[WIDTH-1:0];
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          sync_out[i] <= s3_r[i];
        end
      end
    end
  end

endmodule : umsi_sync
`default_nettype wire

// ==== umsi_irq.sv ====
/*
  Interrupt gate: combines enabled sources onto an active-low request.
  Assumes sources are levels from the same clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module umsi_irq
  import umsi_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [7:0]   enables,
  input  wire umsi_src_type src,
  input  wire logic         modem_pend,
  output var  logic         irq_n
);

  logic tx_en_d_r;
  logic tx_pend_r;
  logic any_req;

  // ****************************************************************
  // Transmit event
  // ****************************************************************
  // Event only on tx level falling below threshold, not on re-enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_en_d_r <= 1'b0;
      tx_pend_r <= 1'b0;
    end else begin
      tx_en_d_r <= src.tx_below;
      if (src.tx_below && !tx_en_d_r) begin
        tx_pend_r <= 1'b1;
      end else if (!src.tx_below || !enables[UMSI_IEN_TX]) begin
        tx_pend_r <= 1'b0;
      end
    end
  end

  always_comb begin
    any_req = (enables[UMSI_IEN_LINE]  && src.line_err)
           || (enables[UMSI_IEN_RX]    && src.rx_data)
           || (enables[UMSI_IEN_TX]    && tx_pend_r)
           || (enables[UMSI_IEN_MODEM] && modem_pend)
           || (enables[UMSI_IEN_XOFF]  && src.xoff_rcvd)
           || (enables[UMSI_IEN_CTS]   && src.cts_rise)
           || (enables[UMSI_IEN_RTS]   && src.rts_rise);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !any_req;
    end
  end

endmodule : umsi_irq
`default_nettype wire

// ==== umsi_regs.sv ====
/*
  Modem status, scratch and interrupt enable register bank, APB slave.
  Assumes modem pins are asynchronous and active low; interrupt sources
  come as levels from the surrounding UART on pclk.
*/
// The placing of the registers and the APB register port were chosen for this implementation.
// Contract
// - Bit 7 reads inverted carrier detect
// - Bit 6 reads inverted ring indicator
// - Bit 5 reads inverted data set ready
// - Bit 4 reads inverted clear to send
// - Bits 3,1,0 latch on change, read clears
// - Bit 2 latches on ring rising edge
// - Pin state register unreliable for modem pins
// - Scratch byte, free storage, no side effects
// - Bits 7,6 enable CTS/RTS rise interrupts
// - Bit 5 enables Xoff interrupt
// - Bit 4 controls sleep mode
// - Bit 3 enables modem status interrupt
// - Bit 2 enables line status interrupt
// - Bit 1 enables transmit interrupt
// - Bit 0 enables receive data interrupt
// - Upper enables writable only with enhanced bit
// - Re-enabling transmit gives no fresh interrupt
// - Request output active on enabled interrupt
// - Enhanced bit gates upper enable writes
// - Loopback feeds control outputs into status
`timescale 1ns/10ps
`default_nettype none
module umsi_regs
  import umsi_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire umsi_modem_in_type modem_in_n,
  input  wire umsi_src_type      irq_src,
  input  wire logic [7:0]        pin_level,
  output var  logic [7:0]        pin_state,
  output var  logic              rts_n,
  output var  logic              dtr_n,
  output var  logic              sleep_en,
  output var  logic              loopback_en,
  output var  logic              interrupt_request_n
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0]        msr_flags_r;
  logic [7:0]        scratch_r;
  logic [7:0]        ien_r;
  logic [7:0]        efr_r;
  logic [7:0]        ioc_r;
  logic [7:0]        mcr_r;
  logic [3:0]        prev_r;
  logic              prev_valid_r;
  logic [3:0]        pins_sync;
  logic [3:0]        eff_n;
  logic [3:0]        changed;
  logic              wr_en;
  logic              rd_en;
  logic              low_lane;
  logic              hit;
  logic              msr_read;
  logic [7:0]        msr_view;
  logic [7:0]        rd_byte;
  logic              modem_pend;
  logic              wr_scr;
  logic              wr_ien;
  logic              wr_efr;
  logic              wr_ioc;
  logic              wr_mcr;

  // Raw pin synchroniser stages
  logic [7:0]        pin_s1_r;
  logic [7:0]        pin_s2_r;
  logic [7:0]        pin_s3_r;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == UMSI_MSR_OFF) || (a == UMSI_SCR_OFF) || (a == UMSI_IEN_OFF)
            || (a == UMSI_EFR_OFF) || (a == UMSI_IOC_OFF) || (a == UMSI_MCR_OFF)
            || (a == UMSI_SRC_OFF);
  endfunction : addr_hit

  function automatic logic [7:0] wr_byte(input logic [7:0] old_v, input logic [31:0] d);
    wr_byte = d[7:0];
    if (old_v == old_v) begin
      wr_byte = d[7:0];
    end
  endfunction : wr_byte

  // ****************************************************************
  // Modem inputs
  // ****************************************************************
  umsi_sync #(
    .WIDTH (4),
    .RST   (UMSI_INPUT_RST)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (modem_in_n),
    .sync_out (pins_sync)
  );

  // Loopback: RTS drives CTS slot, DTR drives DSR slot; CD and RI idle
  always_comb begin
    if (mcr_r[UMSI_MCR_LOOP]) begin
      eff_n = {1'b1, 1'b1, !mcr_r[UMSI_MCR_DTR], !mcr_r[UMSI_MCR_RTS]};
    end else begin
      eff_n = pins_sync;
    end
  end

  // Pins not assigned to modem use read as inactive
  always_comb begin
    msr_view = msr_flags_r;
    msr_view[UMSI_MSR_CTS] = !eff_n[0];
    if (ioc_r[UMSI_IOC_MODEM] || mcr_r[UMSI_MCR_LOOP]) begin
      msr_view[UMSI_MSR_CD]  = !eff_n[3];
      msr_view[UMSI_MSR_RI]  = !eff_n[2];
      msr_view[UMSI_MSR_DSR] = !eff_n[1];
    end else begin
      msr_view[UMSI_MSR_CD]  = 1'b0;
      msr_view[UMSI_MSR_RI]  = 1'b0;
      msr_view[UMSI_MSR_DSR] = 1'b0;
    end
  end

  // ****************************************************************
  // Change detection
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r       <= UMSI_INPUT_RST;
      prev_valid_r <= 1'b0;
    end else begin
      prev_r       <= eff_n;
      prev_valid_r <= 1'b1;
    end
  end

  always_comb begin
    changed = prev_valid_r ? (prev_r ^ eff_n) : 4'h0;
  end

  // ****************************************************************
  // APB decode
  // ****************************************************************
  always_comb begin
    hit      = addr_hit(paddr);
    low_lane = pstrb[0];
    wr_en    = psel && penable && pwrite && hit && low_lane;
    rd_en    = psel && penable && !pwrite;
    msr_read = rd_en && (paddr == UMSI_MSR_OFF);
    // One strobe per register write
    wr_scr   = wr_en && (paddr == UMSI_SCR_OFF);
    wr_ien   = wr_en && (paddr == UMSI_IEN_OFF);
    wr_efr   = wr_en && (paddr == UMSI_EFR_OFF);
    wr_ioc   = wr_en && (paddr == UMSI_IOC_OFF);
    wr_mcr   = wr_en && (paddr == UMSI_MCR_OFF);
  end

  // Set wins over read clear, so an edge during the read survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msr_flags_r <= UMSI_REG_RST;
    end else begin
      // Clear only what the read reported; a flag set after capture survives
      if (msr_read) begin
        msr_flags_r[3:0] <= msr_flags_r[3:0] & ~prdata[3:0];
      end
      if (changed[3]) begin
        msr_flags_r[UMSI_MSR_DCD] <= 1'b1;
      end
      if (changed[2] && eff_n[2]) begin
        msr_flags_r[UMSI_MSR_TERI] <= 1'b1;
      end
      if (changed[1]) begin
        msr_flags_r[UMSI_MSR_DDSR] <= 1'b1;
      end
      if (changed[0]) begin
        msr_flags_r[UMSI_MSR_DCTS] <= 1'b1;
      end
      msr_flags_r[7:4] <= 4'h0;
    end
  end

  // ****************************************************************
  // Scratch
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scratch_r <= UMSI_REG_RST;
    end else if (wr_scr) begin
      scratch_r <= wr_byte(scratch_r, pwdata);
    end
  end

  // ****************************************************************
  // Interrupt enables
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_r <= UMSI_REG_RST;
    end else if (wr_ien) begin
      ien_r[3:0] <= pwdata[3:0];
      if (efr_r[UMSI_EFR_ENH]) begin
        ien_r[7:4] <= pwdata[7:4];
      end
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      efr_r <= UMSI_REG_RST;
    end else if (wr_efr) begin
      efr_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ioc_r <= UMSI_REG_RST;
    end else if (wr_ioc) begin
      ioc_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcr_r <= UMSI_REG_RST;
    end else if (wr_mcr) begin
      mcr_r[4:0] <= pwdata[4:0];
      if (efr_r[UMSI_EFR_ENH]) begin
        mcr_r[7:5] <= pwdata[7:5];
      end
    end
  end

  // ****************************************************************
  // Pin state view
  // ****************************************************************
  // Raw pins cross clock domains: three flops, a bit moves once two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= UMSI_REG_RST;
      pin_s2_r <= UMSI_REG_RST;
      pin_s3_r <= UMSI_REG_RST;
    end else begin
      pin_s1_r <= pin_level;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // Modem-assigned pins read back the raw pin buffer only, not the true level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_state <= UMSI_REG_RST;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (pin_s2_r[i] == pin_s3_r[i]) begin
          pin_state[i] <= pin_s3_r[i];
        end
      end
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  always_comb begin
    case (paddr)
      UMSI_MSR_OFF: rd_byte = msr_view;
      UMSI_SCR_OFF: rd_byte = scratch_r;
      UMSI_IEN_OFF: rd_byte = ien_r;
      UMSI_EFR_OFF: rd_byte = efr_r;
      UMSI_IOC_OFF: rd_byte = ioc_r;
      UMSI_MCR_OFF: rd_byte = mcr_r;
      UMSI_SRC_OFF: rd_byte = {2'b00, irq_src};
      default:      rd_byte = 8'h00;
    endcase
  end

  // Zero-wait slave: answer in the setup cycle's following access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_hit(paddr);
      if (psel && !penable && !pwrite) begin
        prdata <= {24'h000000, rd_byte};
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_comb begin
    modem_pend = |msr_flags_r[3:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_n       <= 1'b1;
      dtr_n       <= 1'b1;
      sleep_en    <= 1'b0;
      loopback_en <= 1'b0;
    end else begin
      rts_n       <= !mcr_r[UMSI_MCR_RTS] || mcr_r[UMSI_MCR_LOOP];
      dtr_n       <= !mcr_r[UMSI_MCR_DTR] || mcr_r[UMSI_MCR_LOOP];
      sleep_en    <= ien_r[UMSI_IEN_SLEEP];
      loopback_en <= mcr_r[UMSI_MCR_LOOP];
    end
  end

  umsi_irq u_irq (
    .pclk       (pclk),
    .presetn    (presetn),
    .enables    (ien_r),
    .src        (irq_src),
    .modem_pend (modem_pend),
    .irq_n      (interrupt_request_n)
  );

endmodule : umsi_regs
`default_nettype wire

// ==== umsi_regs_checker.sv ====
/*
  Checker for the modem status, scratch and interrupt enable bank.
  Assumes it is bound to umsi_regs and that the APB master holds requests.
*/
`timescale 1ns/10ps
`default_nettype none
module umsi_regs_checker
  import umsi_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire umsi_modem_in_type modem_in_n,
  input wire umsi_src_type      irq_src,
  input wire logic              rts_n,
  input wire logic              dtr_n,
  input wire logic              sleep_en,
  input wire logic              loopback_en,
  input wire logic              interrupt_request_n
);
  // ****************************************************************
  // Helper state
  // ****************************************************************
  logic [3:0] quiet_r;
  logic       clean_r;
  logic [3:0] ien_r;
  wire logic  wr_ok  = pready && pwrite && pstrb[0] && !pslverr;
  wire logic  st_rd  = pready && !pwrite && paddr == UMSI_MSR_OFF;
  wire logic  mcr_wr = wr_ok && paddr == UMSI_MCR_OFF;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Quiet time covers the synchroniser, so levels are settled when read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet_r <= 4'h0;
    else if ($changed(modem_in_n) || mcr_wr) quiet_r <= 4'h0;
    else if (quiet_r != 4'hF) quiet_r <= quiet_r + 4'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) clean_r <= 1'b0;
    else if ($changed(modem_in_n) || mcr_wr) clean_r <= 1'b0;
    else if (st_rd && quiet_r >= 4'h8) clean_r <= 1'b1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ien_r <= 4'h0;
    else if (wr_ok && paddr == UMSI_IEN_OFF) ien_r <= pwdata[3:0];
  end

  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    psel && penable && pready;
  endsequence

  apb_answer_a: assert property (setup_s |=> answer_s)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  unmapped_err_a: assert property (pready && paddr > UMSI_SRC_OFF |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  read_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bytes not zero");
  cts_level_a: assert property (st_rd && quiet_r >= 4'h8 && !loopback_en |-> prdata[UMSI_MSR_CTS] == !modem_in_n.cts_n)
    else $error("status CTS level wrong");
  flags_clear_a: assert property (st_rd && clean_r |-> prdata[3:0] == 4'h0)
    else $error("change flags survived a read");
  sleep_src_a: assert property ($changed(sleep_en) |-> $past(wr_ok && paddr == UMSI_IEN_OFF, 2))
    else $error("sleep changed without enable write");
  loop_src_a: assert property ($changed(loopback_en) |-> $past(mcr_wr, 2))
    else $error("loopback changed without control write");
  loop_lines_a: assert property (loopback_en |-> rts_n && dtr_n)
    else $error("control outputs active in loopback");
  irq_on_a: assert property ((ien_r[0] && irq_src.rx_data || ien_r[2] && irq_src.line_err)[*4] |-> !interrupt_request_n)
    else $error("enabled source gave no request");
endmodule : umsi_regs_checker

bind umsi_regs umsi_regs_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .modem_in_n(modem_in_n), .irq_src(irq_src), .rts_n(rts_n), .dtr_n(dtr_n),
  .sleep_en(sleep_en), .loopback_en(loopback_en), .interrupt_request_n(interrupt_request_n));
`default_nettype wire

// ==== umsi_modem_model.sv ====
/*
  Modem side model: drives the active-low control lines.
  Assumes the bench asks for levels; slow mode lags a few cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module umsi_modem_model
  import umsi_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire umsi_modem_in_type want_n,
  input  wire logic              slow,
  output var  umsi_modem_in_type modem_in_n
);
  // ****************************************************************
  // Line driver
  // ****************************************************************
  logic [1:0] lag_r;
  // Lines idle inactive high while nobody asks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modem_in_n <= UMSI_INPUT_RST;
      lag_r      <= 2'h0;
    end else if (want_n != modem_in_n) begin
      if (!slow || lag_r == 2'h3) begin
        modem_in_n <= want_n;
        lag_r      <= 2'h0;
      end else lag_r <= lag_r + 2'h1;
    end
  end
endmodule : umsi_modem_model
`default_nettype wire

// ==== test_uart_modem_status_irq_enable.sv ====
/*
  Self-checking bench for umsi_regs over APB with a modem model.
  Assumes one wait-free access phase and 3-4 cycle pin synchronisation.
*/
`timescale 1ns/10ps
`default_nettype none
module test_uart_modem_status_irq_enable;
  import umsi_pkg::*;
  // ****************************************************************
  // Bench signals
  // ****************************************************************
  logic              pclk, presetn, psel, penable, pwrite, slow;
  logic [7:0]        paddr, pin_state;
  logic [31:0]       pwdata, prdata;
  logic              pready, pslverr, rts_n, dtr_n, sleep_en, loopback_en, irq_n;
  umsi_modem_in_type want_n, modem_in_n;
  umsi_src_type      src;
  int                n_mismatch, checks;

  umsi_modem_model u_modem (.pclk(pclk), .presetn(presetn), .want_n(want_n), .slow(slow),
    .modem_in_n(modem_in_n));
  umsi_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .modem_in_n(modem_in_n), .irq_src(src), .pin_level(8'h3C), .pin_state(pin_state), .rts_n(rts_n),
    .dtr_n(dtr_n), .sleep_en(sleep_en), .loopback_en(loopback_en), .interrupt_request_n(irq_n));

  task automatic conclude;
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 8'h00, r, e);
    chk(r, {24'h0, exp});
  endtask : rd

  task automatic t_reset;
    rd(UMSI_MSR_OFF, 8'h00);
    rd(UMSI_IEN_OFF, 8'h00);
    chk(sleep_en, 1'b0);
  endtask : t_reset

  task automatic t_scratch;
    logic [31:0] r;
    logic e;
    wr(UMSI_SCR_OFF, 8'hA5);
    rd(UMSI_IEN_OFF, 8'h00);
    rd(UMSI_SCR_OFF, 8'hA5);
    wr(UMSI_SCR_OFF, 8'h5A);
    rd(UMSI_SCR_OFF, 8'h5A);
    xfer(1'b0, 8'h40, 8'h00, r, e);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk({24'h0, pin_state}, 32'h3C);
  endtask : t_scratch

  task automatic t_ien;
    wr(UMSI_IEN_OFF, 8'hFF);
    rd(UMSI_IEN_OFF, 8'h0F);
    wr(UMSI_EFR_OFF, 8'h10);
    wr(UMSI_IEN_OFF, 8'hFF);
    rd(UMSI_IEN_OFF, 8'hFF);
    chk(sleep_en, 1'b1);
    wr(UMSI_EFR_OFF, 8'h00);
    wr(UMSI_IEN_OFF, 8'h00);
    rd(UMSI_IEN_OFF, 8'hF0);
    wr(UMSI_EFR_OFF, 8'h10);
    wr(UMSI_IEN_OFF, 8'h00);
    repeat (2) @(posedge pclk);
    chk(sleep_en, 1'b0);
  endtask : t_ien

  // Pin table: levels {cd,ri,dsr,cts} and the status byte they give
  task automatic t_modem;
    logic [3:0] pv [6];
    logic [7:0] ev [6];
    pv = '{4'b1110, 4'b1010, 4'b1110, 4'b0110, 4'b0100, 4'b1111};
    ev = '{8'h11, 8'h50, 8'h14, 8'h98, 8'hB2, 8'h0B};
    wr(UMSI_IOC_OFF, 8'h02);
    for (int i = 0; i < 6; i++) begin
      slow   <= (i == 3);
      want_n <= pv[i];
      repeat (14) @(posedge pclk);
      rd(UMSI_MSR_OFF, ev[i]);
      rd(UMSI_MSR_OFF, ev[i] & 8'hF0);
    end
  endtask : t_modem

  task automatic t_irq;
    wr(UMSI_IEN_OFF, 8'h08);
    want_n <= 4'b1110;
    repeat (14) @(posedge pclk);
    chk(irq_n, 1'b0);
    rd(UMSI_MSR_OFF, 8'h11);
    repeat (4) @(posedge pclk);
    chk(irq_n, 1'b1);
    wr(UMSI_IEN_OFF, 8'h01);
    src.rx_data <= 1'b1;
    repeat (5) @(posedge pclk);
    chk(irq_n, 1'b0);
    src.rx_data <= 1'b0;
    wr(UMSI_IEN_OFF, 8'h02);
    src.tx_below <= 1'b1;
    repeat (5) @(posedge pclk);
    chk(irq_n, 1'b0);
    wr(UMSI_IEN_OFF, 8'h00);
    wr(UMSI_IEN_OFF, 8'h02);
    repeat (5) @(posedge pclk);
    chk(irq_n, 1'b1);
    src.tx_below <= 1'b0;
    wr(UMSI_IEN_OFF, 8'h20);
    src.xoff_rcvd <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(irq_n, 1'b0);
    src.xoff_rcvd <= 1'b0;
    src.cts_rise  <= 1'b1;
    src.rts_rise  <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(irq_n, 1'b1);
    wr(UMSI_IEN_OFF, 8'hC0);
    repeat (3) @(posedge pclk);
    chk(irq_n, 1'b0);
    src <= '0;
  endtask : t_irq

  task automatic t_loop;
    wr(UMSI_MCR_OFF, 8'h11);
    rd(UMSI_MSR_OFF, 8'h23);
    chk({loopback_en, rts_n, dtr_n}, 3'h7);
    repeat (14) @(posedge pclk);
    rd(UMSI_MSR_OFF, 8'h20);
    wr(UMSI_MCR_OFF, 8'h03);
    repeat (2) @(posedge pclk);
    chk({loopback_en, rts_n, dtr_n}, 3'h0);
  endtask : t_loop

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    conclude();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    slow = 1'b0; want_n = 4'hF; src = '0; n_mismatch = 0; checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_scratch();
    t_ien();
    t_modem();
    t_irq();
    t_loop();
    conclude();
  end
endmodule : test_uart_modem_status_irq_enable
`default_nettype wire
